//--- dbm_lane_mask.sv
// Purpose: Write side of a double-rate separate-I/O SRAM with lane masks
// Assumes: Link clocks are slow against ref_clk and sampled as pins
// Notes: Read datapath is outside; data outputs stay tri-stated here
`timescale 1ns/100ps
`include "dbm_consts.svh"

module dbm_lane_mask
    import dbm_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic input_timing_pos,
    input wire logic input_timing_neg,
    input wire dbm_pins_t pins,
    input wire logic [1:0] org_strap,
    input wire logic [`DBM_ADDR_W-1:0] peek_addr,
    output logic [`DBM_DATA_W-1:0] peek_data,
    output logic q_oe_n
);

    dbm_pins_t pin_s1_reg, pin_s2_reg, pin_s3_reg;
    logic [1:0] clk_s1_reg, clk_s2_reg, clk_s3_reg;
    logic pos_lvl_reg, neg_lvl_reg;
    logic pos_rise, neg_rise, wr_cmd;
    dbm_org_t org_reg;
    logic org_done_reg;
    dbm_state_t state_reg, state_next;
    logic [`DBM_ADDR_W-1:0] base_reg, pend_reg;
    logic pend_vld_reg;
    dbm_wr_t wr_reg;
    logic [`DBM_DATA_W-1:0] bit_en;

    // Three-stage sampling of every pin; clocks and data stay aligned
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_s1_reg <= '0;
            pin_s2_reg <= '0;
            pin_s3_reg <= '0;
            clk_s1_reg <= 2'h0;
            clk_s2_reg <= 2'h0;
            clk_s3_reg <= 2'h0;
        end
        else
        begin
            pin_s1_reg <= pins;
            pin_s2_reg <= pin_s1_reg;
            pin_s3_reg <= pin_s2_reg;
            clk_s1_reg <= {input_timing_neg, input_timing_pos};
            clk_s2_reg <= clk_s1_reg;
            clk_s3_reg <= clk_s2_reg;
        end
    end

    // Clock levels move only when stages two and three agree
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pos_lvl_reg <= 1'b0;
            neg_lvl_reg <= 1'b0;
        end
        else
        begin
            if (clk_s2_reg[0] == clk_s3_reg[0])
            begin
                pos_lvl_reg <= clk_s3_reg[0];
            end
            if (clk_s2_reg[1] == clk_s3_reg[1])
            begin
                neg_lvl_reg <= clk_s3_reg[1];
            end
        end
    end

    // Rising edges of the two input clocks, one pulse each
    assign pos_rise = clk_s2_reg[0] && clk_s3_reg[0] && !pos_lvl_reg;
    assign neg_rise = clk_s2_reg[1] && clk_s3_reg[1] && !neg_lvl_reg;
    // Write request: strobe low and read/write select low
    assign wr_cmd = pos_rise && !pin_s3_reg.access_strobe_n
                    && !pin_s3_reg.read_write_select;

    // Strap caught one clock after reset release, not under reset
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            org_reg <= dbm_org_t'(`DBM_ORG_RST);
            org_done_reg <= 1'b0;
        end
        else if (!org_done_reg)
        begin
            org_reg <= dbm_org_t'(org_strap);
            org_done_reg <= 1'b1;
        end
    end

    // Per-bit write enable from the active-low lane selects
    for (genvar b = 0; b < `DBM_DATA_W; b++)
    begin : g_lane
        always_comb
        begin
            case (org_reg)
                DBM_ORG8: bit_en[b] = (b < 2 * `DBM_NIB_W)
                    && !pin_s3_reg.sel_n[(b / `DBM_NIB_W) % 2];
                DBM_ORG9: bit_en[b] = (b < `DBM_BYTE_W)
                    && !pin_s3_reg.sel_n[0];
                DBM_ORG18: bit_en[b] = (b < 2 * `DBM_BYTE_W)
                    && !pin_s3_reg.sel_n[b / `DBM_BYTE_W];
                default: bit_en[b] = !pin_s3_reg.sel_n[b / `DBM_BYTE_W];
            endcase
        end
    end

    // Burst sequencer: idle, first word at pos rise, second at neg rise
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            DBM_ST_IDLE:
            begin
                if (wr_cmd)
                begin
                    state_next = DBM_ST_WORD0;
                end
            end
            DBM_ST_WORD0:
            begin
                if (pos_rise)
                begin
                    state_next = DBM_ST_WORD1;
                end
            end
            DBM_ST_WORD1:
            begin
                if (neg_rise)
                begin
                    state_next = pend_vld_reg ? DBM_ST_WORD0 : DBM_ST_IDLE;
                end
            end
            default: state_next = DBM_ST_IDLE;
        endcase
    end

    // Powers up deselected
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= DBM_ST_IDLE;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // Burst address, plus a back-to-back write issued in cycle t + 1
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            base_reg <= '0;
            pend_reg <= '0;
            pend_vld_reg <= 1'b0;
        end
        else
        begin
            if (state_reg == DBM_ST_IDLE && wr_cmd)
            begin
                base_reg <= pin_s3_reg.addr;
            end
            else if (state_reg == DBM_ST_WORD0 && wr_cmd)
            begin
                pend_reg <= pin_s3_reg.addr;
                pend_vld_reg <= 1'b1;
            end
            else if (state_reg == DBM_ST_WORD1 && neg_rise && pend_vld_reg)
            begin
                base_reg <= pend_reg;
                pend_vld_reg <= 1'b0;
            end
        end
    end

    // One masked write per data portion; all selects high gives no bits
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_reg <= '0;
        end
        else
        begin
            wr_reg.en <= 1'b0;
            if (state_reg == DBM_ST_WORD0 && pos_rise)
            begin
                wr_reg.en <= 1'b1;
                wr_reg.addr <= base_reg;
                wr_reg.data <= pin_s3_reg.data;
                wr_reg.bits <= bit_en;
            end
            else if (state_reg == DBM_ST_WORD1 && neg_rise)
            begin
                wr_reg.en <= 1'b1;
                wr_reg.addr <= base_reg + `DBM_ADDR_W'(1);
                wr_reg.data <= pin_s3_reg.data;
                wr_reg.bits <= bit_en;
            end
        end
    end

    // Read port lives elsewhere, so outputs stay tri-stated
    assign q_oe_n = 1'b1;

    dbm_mem u_mem (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .wr(wr_reg),
        .rd_addr(peek_addr),
        .rd_data(peek_data)
    );

    a_nibble_lanes: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wr_reg.en && org_reg == DBM_ORG8 |-> wr_reg.bits ==
        {28'h0, {4{!$past(pin_s3_reg.sel_n[1])}}, {4{!$past(pin_s3_reg.sel_n[0])}}})
        else $error("Nibble lane enables wrong");
    a_byte_pair: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wr_reg.en && org_reg == DBM_ORG18 |-> wr_reg.bits ==
        {18'h0, {9{!$past(pin_s3_reg.sel_n[1])}}, {9{!$past(pin_s3_reg.sel_n[0])}}})
        else $error("Byte pair enables wrong");
    a_single_byte: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wr_reg.en && org_reg == DBM_ORG9 |->
        wr_reg.bits == {27'h0, {9{!$past(pin_s3_reg.sel_n[0])}}})
        else $error("Single byte enable wrong");
    a_quad_bytes: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wr_reg.en && org_reg == DBM_ORG36 |-> wr_reg.bits[35:27]
        == {9{!$past(pin_s3_reg.sel_n[3])}} && wr_reg.bits[26:18]
        == {9{!$past(pin_s3_reg.sel_n[2])}})
        else $error("Upper byte lane enables wrong");
    a_all_masked: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wr_reg.en && $past(pin_s3_reg.sel_n) == 4'hf |-> wr_reg.bits == '0)
        else $error("Bits written with every select high");
    a_second_portion: assert property (@(posedge ref_clk) disable iff (!rst_n)
        state_reg == DBM_ST_WORD1 && neg_rise |=> wr_reg.en
        && wr_reg.bits == $past(bit_en) && wr_reg.data == $past(pin_s3_reg.data))
        else $error("Second portion not sampled at negative rise");
    a_first_portion: assert property (@(posedge ref_clk) disable iff (!rst_n)
        state_reg == DBM_ST_WORD0 && pos_rise |=> wr_reg.en
        && wr_reg.addr == $past(base_reg) && state_reg == DBM_ST_WORD1)
        else $error("First word not taken at positive rise");
    a_desel_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n)
        state_reg == DBM_ST_IDLE |=> !wr_reg.en && q_oe_n)
        else $error("Write or drive while deselected");
    a_burst_next: assert property (@(posedge ref_clk) disable iff (!rst_n)
        state_reg == DBM_ST_WORD1 && neg_rise |=>
        wr_reg.addr == $past(base_reg) + `DBM_ADDR_W'(1))
        else $error("Second word not at A + 1");
    a_issue_cycle: assert property (@(posedge ref_clk) disable iff (!rst_n)
        state_reg == DBM_ST_IDLE && wr_cmd |=> state_reg == DBM_ST_WORD0
        && base_reg == $past(pin_s3_reg.addr) ##1 !wr_reg.en)
        else $error("Write issue not taken");

endmodule // dbm_lane_mask

//--- dbm_consts.svh
// Purpose: Constants for the write lane masking block
// Assumes: Included by the package and the design modules
// Notes: Array depth is kept small for this model of the array
`ifndef DBM_CONSTS_SVH
`define DBM_CONSTS_SVH

`define DBM_DATA_W 36
`define DBM_LANES 4
`define DBM_ADDR_W 4
`define DBM_DEPTH 16
`define DBM_NIB_W 4
`define DBM_BYTE_W 9
`define DBM_SYNC_STAGES 3
`define DBM_ORG_RST 2'h3

`endif

//--- dbm_pkg.sv
// Purpose: Types shared by the write lane masking block
// Assumes: dbm_consts.svh gives the widths
// Notes: None
`include "dbm_consts.svh"

package dbm_pkg;

    // Organisation strap codes
    typedef enum logic [1:0] {
        DBM_ORG8,
        DBM_ORG9,
        DBM_ORG18,
        DBM_ORG36
    } dbm_org_t;

    // Write burst sequencer states
    typedef enum logic [1:0] {
        DBM_ST_IDLE,
        DBM_ST_WORD0,
        DBM_ST_WORD1
    } dbm_state_t;

    // Pins from the memory controller, sampled together
    typedef struct packed {
        logic [`DBM_ADDR_W-1:0] addr;
        logic [`DBM_DATA_W-1:0] data;
        logic [`DBM_LANES-1:0] sel_n;
        logic access_strobe_n;
        logic read_write_select;
    } dbm_pins_t;

    // One masked array write
    typedef struct packed {
        logic en;
        logic [`DBM_ADDR_W-1:0] addr;
        logic [`DBM_DATA_W-1:0] data;
        logic [`DBM_DATA_W-1:0] bits;
    } dbm_wr_t;

endpackage

//--- dbm_mem.sv
// Purpose: Storage array with a per-bit write enable
// Assumes: One write and one read per clock
// Notes: Read data come from a register, one cycle after the address
`timescale 1ns/100ps
`include "dbm_consts.svh"

module dbm_mem
    import dbm_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire dbm_wr_t wr,
    input wire logic [`DBM_ADDR_W-1:0] rd_addr,
    output logic [`DBM_DATA_W-1:0] rd_data
);

    logic [`DBM_DATA_W-1:0] mem_q [`DBM_DEPTH];

    // Only enabled bits change, masked bits keep their old value
    // One process owns the array, so a variable index never splits its drivers
    always_ff @(posedge ref_clk)
    begin
        if (wr.en)
        begin
            mem_q[wr.addr] <= (mem_q[wr.addr] & ~wr.bits) | (wr.data & wr.bits);
        end
    end

    // Registered read for observation of the array
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rd_data <= '0;
        end
        else
        begin
            rd_data <= mem_q[rd_addr];
        end
    end

    a_masked_kept: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wr.en |=> ((mem_q[$past(wr.addr)] & ~$past(wr.bits))
                   == ($past(mem_q[wr.addr]) & ~$past(wr.bits))))
        else $error("Masked lane changed during write");

endmodule // dbm_mem

//--- dbm_ctl_model.sv
// Purpose: Memory controller model driving the write port of the lane masking block
// Assumes: Link clocks are slow against ref_clk; every level is held 4 cycles or more
// Notes: Pins it has released show the inverse of their last value, except addr after chain, which keeps the second address
`timescale 1ns/100ps
`include "dbm_consts.svh"

module dbm_ctl_model
    import dbm_pkg::*;
(
    input wire logic ref_clk,
    output logic input_timing_pos,
    output logic input_timing_neg,
    output dbm_pins_t pins
);
    // Parked and deselected from time zero
    initial
    begin
        input_timing_pos = 1'b0;
        input_timing_neg = 1'b0;
        pins = '0;
        pins.sel_n = 4'hf;
        pins.access_strobe_n = 1'b1;
        pins.read_write_select = 1'b1;
    end

    // Changes land just after a rising edge, always by the same delay
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    // Clock levels move, then 4 cycles pass so the block sees a clean edge
    task automatic clk_to(input logic p, input logic n);
        input_timing_pos = p;
        input_timing_neg = n;
        cyc(4);
    endtask

    // Issue at a positive rise, then the negative rise of cycle t
    task automatic issue(input logic [3:0] a, input logic rw);
        pins.addr = a;
        pins.read_write_select = rw;
        pins.access_strobe_n = 1'b0;
        cyc(4);
        clk_to(1'b1, 1'b0);
        pins.access_strobe_n = 1'b1;
        pins.addr = ~a;
        pins.data = ~pins.data;
        cyc(4);
        clk_to(1'b0, 1'b1);
    endtask

    // Two data portions of cycle t + 1; a strobe left low issues the next write
    task automatic words(input logic [35:0] d0, input logic [3:0] s0, input logic [35:0] d1,
                         input logic [3:0] s1);
        pins.data = d0;
        pins.sel_n = s0;
        cyc(4);
        clk_to(1'b1, 1'b0);
        pins.access_strobe_n = 1'b1;
        pins.data = d1;
        pins.sel_n = s1;
        cyc(4);
        clk_to(1'b0, 1'b1);
        pins.data = ~d1;
        pins.sel_n = ~s1;
        cyc(4);
    endtask

    // One two-word burst; clocks stand still outside it
    task automatic burst(input logic [3:0] a, input logic rw, input logic [35:0] d0,
                         input logic [3:0] s0, input logic [35:0] d1, input logic [3:0] s1);
        issue(a, rw);
        words(d0, s0, d1, s1);
        // Equal levels while stopped give the quickest restart
        clk_to(1'b0, 1'b0);
    endtask

    // Back-to-back pair: the second write is issued at the first word's positive rise
    task automatic chain(input logic [3:0] a, input logic [3:0] b, input logic [35:0] d0,
                         input logic [35:0] d1);
        issue(a, 1'b0);
        pins.addr = b;
        pins.access_strobe_n = 1'b0;
        words(d0, 4'h0, ~d0, 4'h0);
        words(d1, 4'h0, ~d1, 4'h0);
        clk_to(1'b0, 1'b0);
    endtask
endmodule // dbm_ctl_model

//--- dbm_lane_mask_tb_top.sv
// Purpose: Self-checking bench for the write lane masking block
// Assumes: dbm_ctl_model drives the write port; the array is seen through peek
// Notes: Each organisation needs its own reset, as the strap is caught only then
`timescale 1ns/100ps
`include "dbm_consts.svh"

module dbm_lane_mask_tb_top
    import dbm_pkg::*;
;
    logic ref_clk;
    logic rst_n;
    logic [1:0] org_strap;
    logic [3:0] peek_addr;
    logic [35:0] peek_data;
    logic q_oe_n;
    logic input_timing_pos;
    logic input_timing_neg;
    dbm_pins_t pins;
    int num_errors;
    int check_count;
    logic [35:0] want_mem [16];
    logic [3:0] burst_cnt;

    // 100 MHz clock
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    dbm_lane_mask uut (.ref_clk(ref_clk), .rst_n(rst_n), .input_timing_pos(input_timing_pos),
        .input_timing_neg(input_timing_neg), .pins(pins), .org_strap(org_strap),
        .peek_addr(peek_addr), .peek_data(peek_data), .q_oe_n(q_oe_n));

    dbm_ctl_model ctl (.ref_clk(ref_clk), .input_timing_pos(input_timing_pos),
        .input_timing_neg(input_timing_neg), .pins(pins));

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic cmp_word(input logic [35:0] got, input logic [35:0] want);
        check_count++;
        if (got !== want)
        begin
            num_errors++;
            $display("unexpected at %0t: word %h, wanted %h", $time, got, want);
        end
    endtask

    task automatic cmp_bit(input logic got, input logic want);
        check_count++;
        if (got !== want)
        begin
            num_errors++;
            $display("unexpected at %0t: flag %b, wanted %b", $time, got, want);
        end
    endtask

    // Bits that a portion writes, from the organisation and its active-low selects
    function automatic logic [35:0] lane_bits(input logic [1:0] org, input logic [3:0] s);
        case (org)
            2'h0: return {28'h0, {4{~s[1]}}, {4{~s[0]}}};
            2'h1: return {27'h0, {9{~s[0]}}};
            2'h2: return {18'h0, {9{~s[1]}}, {9{~s[0]}}};
            default: return {{9{~s[3]}}, {9{~s[2]}}, {9{~s[1]}}, {9{~s[0]}}};
        endcase
    endfunction

    // Reset with a new strap; outputs are checked while reset is held
    task automatic do_reset(input logic [1:0] org);
        org_strap = org;
        rst_n = 1'b0;
        cyc(5);
        cmp_word(peek_data, 36'h0);
        cmp_bit(q_oe_n, 1'b1);
        rst_n = 1'b1;
        cyc(3);
    endtask

    // A burst with fresh data; the expected array follows only for writes
    task automatic wr(input logic [3:0] a, input logic rw, input logic [3:0] s0,
                      input logic [3:0] s1);
        logic [35:0] d0;
        logic [35:0] m;
        d0 = 36'h5a5a5a5a5 ^ {9{burst_cnt}};
        burst_cnt++;
        ctl.burst(a, rw, d0, s0, ~d0, s1);
        cyc(4);
        if (!rw)
        begin
            m = lane_bits(org_strap, s0);
            want_mem[a] = (want_mem[a] & ~m) | (d0 & m);
            m = lane_bits(org_strap, s1);
            want_mem[a + 4'h1] = (want_mem[a + 4'h1] & ~m) | (~d0 & m);
        end
    endtask

    // Words at A + 0 and A + 1 must match; outputs must be tri-stated once both are read
    task automatic chk_pair(input logic [3:0] a);
        peek_addr = a;
        cyc(3);
        cmp_word(peek_data, want_mem[a]);
        peek_addr = a + 4'h1;
        cyc(3);
        cmp_word(peek_data, want_mem[a + 4'h1]);
        cmp_bit(q_oe_n, 1'b1);
    endtask

    task automatic t_prefill();
        do_reset(2'h3);
        for (int a = 0; a < 16; a += 2)
        begin
            wr(a[3:0], 1'b0, 4'h0, 4'h0);
            chk_pair(a[3:0]);
        end
        $display("t_prefill done");
    endtask

    // Each select pattern in the first portion, its inverse in the second
    task automatic t_lanes(input logic [1:0] org, input int n, input logic [3:0] a);
        logic [3:0] v;
        do_reset(org);
        for (int s = 0; s < (1 << n); s++)
        begin
            v = s[3:0];
            // Unused selects held low: they must not widen the write
            wr((org == 2'h3) ? v : a, 1'b0, v, ~v & 4'((1 << n) - 1));
            chk_pair((org == 2'h3) ? v : a);
        end
        $display("t_lanes done for organisation %0d", org);
    endtask

    // A read command carries no write, even with every select low
    task automatic t_read();
        wr(4'h9, 1'b1, 4'h0, 4'h0);
        chk_pair(4'h9);
        $display("t_read done");
    endtask

    // Back-to-back writes in the 36-bit organisation, all selects low
    task automatic t_chain();
        ctl.chain(4'h2, 4'h6, 36'h123456789, 36'h3c3c3c3c3);
        cyc(4);
        want_mem[2] = 36'h123456789;
        want_mem[3] = ~36'h123456789;
        want_mem[6] = 36'h3c3c3c3c3;
        want_mem[7] = ~36'h3c3c3c3c3;
        chk_pair(4'h2);
        chk_pair(4'h6);
        $display("t_chain done");
    endtask

    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Main sequence, 15 is the wrap case in the 36-bit loop
    initial
    begin
        rst_n = 1'b0;
        org_strap = 2'h3;
        peek_addr = 4'h0;
        num_errors = 0;
        check_count = 0;
        burst_cnt = 4'h0;
        t_prefill();
        t_chain();
        t_lanes(2'h3, 4, 4'h0);
        t_lanes(2'h2, 2, 4'h5);
        t_lanes(2'h1, 1, 4'h7);
        t_lanes(2'h0, 2, 4'hc);
        t_read();
        wrap_up();
    end

    // Whole run is near 1900 cycles; 50000 means a hang
    initial
    begin
        #500000;
        num_errors++;
        $display("unexpected at %0t: watchdog expired", $time);
        wrap_up();
    end
endmodule // dbm_lane_mask_tb_top
